// [design/vdc_top.sv]
// Two-channel detector output unit: input synchronisers, reset qualification, recovery, channels
`timescale 1ns/1ps
module vdc_top #(
    parameter int unsigned RECOVER_CYC = vdc_pkg::RECOVER_CYC,
    parameter int unsigned PULSE_CYC = vdc_pkg::PULSE_CYC
) (
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Controller reset pin, ground-true
    input wire logic det_reset_n,
    // Sensing front end, one bit per channel
    input wire logic [1:0] veh_detect,
    input wire logic [1:0] winding_open,
    input wire logic [1:0] winding_short,
    // Front-panel mode switches, 1 = presence
    input wire logic [1:0] mode_presence,
    // Open-collector controller outputs, conducting while oe_n is low
    output logic [1:0] ctl_out_o,
    output logic [1:0] ctl_out_oe_n,
    // Front-panel indicators
    output logic [1:0] ind_lamp
);

    vdc_pkg::vdc_top_state_t st_reg;
    vdc_pkg::vdc_top_state_t st_next;
    vdc_pkg::vdc_chan_in_t chan_in [2];
    vdc_pkg::vdc_chan_out_t chan_out [2];
    logic chan_en;
    logic det_rst_low;

    assign det_rst_low = !st_reg.sync2[vdc_pkg::SY_RST];
    assign chan_en = !st_reg.recovering;

    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = {det_reset_n, winding_short, winding_open, mode_presence, veh_detect};
        st_next.sync2 = st_reg.sync1;
        if (det_rst_low)
        begin
            // Count how long the pin has been low; short glitches never reach the limit
            if (st_reg.rst_cnt < vdc_pkg::RST_CNT_W'(vdc_pkg::RST_MIN_CYC))
                st_next.rst_cnt = st_reg.rst_cnt + vdc_pkg::RST_CNT_W'(1);
            if (st_reg.rst_cnt == vdc_pkg::RST_CNT_W'(vdc_pkg::RST_MIN_CYC - 1))
            begin
                st_next.recovering = 1'b1;
                st_next.rec_cnt = vdc_pkg::CNT_W'(0);
            end
            else if (st_reg.rst_cnt == vdc_pkg::RST_CNT_W'(vdc_pkg::RST_MIN_CYC))
                st_next.rec_cnt = vdc_pkg::CNT_W'(0);
        end
        else
        begin
            st_next.rst_cnt = vdc_pkg::RST_CNT_W'(0);
        end
        // Recovery time is held while a qualified reset is still on the pin and runs again once the pin is high
        if (st_reg.recovering && !(det_rst_low && st_reg.rst_cnt >= vdc_pkg::RST_CNT_W'(vdc_pkg::RST_MIN_CYC - 1)))
        begin
            if (st_reg.rec_cnt >= vdc_pkg::CNT_W'(RECOVER_CYC - 1))
                st_next.recovering = 1'b0;
            else
                st_next.rec_cnt = st_reg.rec_cnt + vdc_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st_reg <= vdc_pkg::TOP_RST;
        else
            st_reg <= st_next;
    end

    // Two independent channel instances with nothing shared but clock, reset and enable
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        always_comb
        begin
            chan_in[c].veh = st_reg.sync2[vdc_pkg::SY_VEH + c];
            chan_in[c].presence_mode = st_reg.sync2[vdc_pkg::SY_MODE + c];
            chan_in[c].fault = st_reg.sync2[vdc_pkg::SY_OPEN + c] | st_reg.sync2[vdc_pkg::SY_SHORT + c];
        end

        vdc_chan #(
            .PULSE_CYC(PULSE_CYC)
        ) u_chan (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .enable(chan_en),
            .inp(chan_in[c]),
            .outp(chan_out[c])
        );

        assign ctl_out_oe_n[c] = chan_out[c].drive_n;
        assign ind_lamp[c] = chan_out[c].lamp;
    end

    // Open collector only ever pulls low
    assign ctl_out_o = 2'h0;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    localparam int unsigned RST_LAST = vdc_pkg::RST_MIN_CYC - 1;

    // Pulse width counter seen from the output pins, gated by the synchronised mode and fault inputs
    logic [vdc_pkg::CNT_W-1:0] low_len [2];
    for (genvar c = 0; c < 2; c++)
    begin : g_len
        always_ff @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
                low_len[c] <= 32'h0;
            else if (!ctl_out_oe_n[c] && !chan_in[c].fault && !chan_in[c].presence_mode)
                // Only pulse-mode closures are timed; a fault or presence hold restarts the count
                low_len[c] <= low_len[c] + 32'h1;
            else
                low_len[c] <= 32'h0;
        end
    end

    chk_reset_qualify: assert property (det_rst_low && st_reg.rst_cnt == 9'(RST_LAST) |=> st_reg.recovering)
        else $error("qualified reset did not start recovery");

    chk_reset_glitch: assert property ($rose(st_reg.recovering) |-> $past(st_reg.rst_cnt) == 9'(RST_LAST))
        else $error("recovery started without a qualified reset");

    chk_recover_end: assert property (st_reg.recovering && !det_rst_low && st_reg.rec_cnt == 32'(RECOVER_CYC - 1)
        |=> !st_reg.recovering)
        else $error("recovery did not end on time");

    for (genvar c = 0; c < 2; c++)
    begin : g_chk
        sequence s_quiet;
            ctl_out_oe_n[c] && !ind_lamp[c];
        endsequence

        sequence s_hold_low;
            !ctl_out_oe_n[c] [*8];
        endsequence

        chk_quiet_recover: assert property (st_reg.recovering |=> s_quiet)
            else $error("channel active during recovery");

        chk_fault_drive: assert property (chan_en && chan_in[c].fault |=> !ctl_out_oe_n[c] && ind_lamp[c])
            else $error("fault did not force output on");

        chk_presence_follow: assert property (chan_en && !chan_in[c].fault && chan_in[c].presence_mode
            |=> ctl_out_oe_n[c] == !$past(chan_in[c].veh))
            else $error("presence output does not follow vehicle");

        chk_pulse_hold: assert property (chan_en && !chan_in[c].presence_mode && !chan_in[c].fault
            && $fell(ctl_out_oe_n[c]) ##1 chan_en && !chan_in[c].presence_mode && !chan_in[c].fault
            |-> s_hold_low)
            else $error("pulse closure ended early");

        chk_pulse_len: assert property (!chan_in[c].presence_mode && !chan_in[c].fault && !ctl_out_oe_n[c]
            |-> low_len[c] < 32'(PULSE_CYC))
            else $error("pulse closure too long");

        chk_lamp_show: assert property (chan_en && !chan_in[c].fault && chan_in[c].veh |=> ind_lamp[c])
            else $error("indicator missed a vehicle");
    end

    // A qualified reset pin held low keeps the unit in recovery
    chk_reset_hold: assert property (det_rst_low && st_reg.rst_cnt >= 9'(RST_LAST) |=> st_reg.recovering)
        else $error("recovery released while reset pin still low");

    // The data side of the open-collector outputs never drives high
    chk_open_drain: assert property (ctl_out_o == 2'h0)
        else $error("open-collector data not low");

    for (genvar c = 0; c < 2; c++)
    begin : g_chk_pulse
        // Idle pulse-mode channel: an output that is off means no closure is running
        sequence s_pulse_ready;
            chan_en && !chan_in[c].presence_mode && !chan_in[c].fault && ctl_out_oe_n[c];
        endsequence

        sequence s_pulse_run;
            chan_en && !chan_in[c].presence_mode && !chan_in[c].fault && !ctl_out_oe_n[c];
        endsequence

        chk_pulse_entry: assert property (s_pulse_ready and (chan_in[c].veh && !$past(chan_in[c].veh))
            |=> !ctl_out_oe_n[c])
            else $error("vehicle entry gave no closure");

        chk_pulse_end: assert property (s_pulse_run and (low_len[c] == 32'(PULSE_CYC - 1))
            |=> ctl_out_oe_n[c])
            else $error("pulse closure not released on time");

        chk_lamp_clear: assert property (chan_en && !chan_in[c].fault && !chan_in[c].veh |=> !ind_lamp[c])
            else $error("indicator lit with no vehicle");
    end

    chk_chan_indep: assert property (chan_en && chan_in[0].presence_mode && !chan_in[0].fault && !chan_in[0].veh
        && chan_in[1].veh |=> ctl_out_oe_n[0])
        else $error("channel 1 vehicle disturbed channel 0");

endmodule

// [design/vdc_pkg.sv]
// Shared constants, carrier structs and state types for the two-channel detector output logic
package vdc_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
    localparam int unsigned NUM_CHAN = 2;

    // Least reset pulse width, rounded up to whole cycles
    localparam int unsigned RST_MIN_NS = 15000;
    localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RST_CNT_W = 9;

    // Recovery after reset or power-up; longest time, rounded down
    localparam int unsigned RECOVER_MS = 2000;
    localparam int unsigned RECOVER_CYC = RECOVER_MS * CLK_KHZ;

    // Pulse-mode closure, nominal 150 ms (tolerance 25 ms)
    localparam int unsigned PULSE_MS = 150;
    localparam int unsigned PULSE_CYC = PULSE_MS * CLK_KHZ;

    localparam int unsigned CNT_W = 32;
    localparam int unsigned SYNC_W = 9;

    typedef struct packed {
        logic veh;
        logic fault;
        logic presence_mode;
    } vdc_chan_in_t;

    typedef struct packed {
        logic drive_n;
        logic lamp;
    } vdc_chan_out_t;

    typedef struct packed {
        logic veh_prev;
        logic [CNT_W-1:0] pulse_cnt;
        vdc_chan_out_t out;
    } vdc_chan_state_t;

    localparam vdc_chan_state_t CHAN_RST = '{veh_prev: 1'b0, pulse_cnt: 32'h0, out: '{drive_n: 1'b1, lamp: 1'b0}};

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic [CNT_W-1:0] rec_cnt;
        logic recovering;
    } vdc_top_state_t;

    // Sync vector layout: {det_reset_n, short[1:0], open[1:0], mode[1:0], veh[1:0]}
    localparam int unsigned SY_VEH = 0;
    localparam int unsigned SY_MODE = 2;
    localparam int unsigned SY_OPEN = 4;
    localparam int unsigned SY_SHORT = 6;
    localparam int unsigned SY_RST = 8;
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h100;

    localparam vdc_top_state_t TOP_RST = '{sync1: SYNC_RST, sync2: SYNC_RST, rst_cnt: 9'h000,
                                           rec_cnt: 32'h0, recovering: 1'b1};

endpackage

// [design/vdc_chan.sv]
// One detection channel: mode handling, pulse timer, fault override, indicator
`timescale 1ns/1ps
module vdc_chan #(
    parameter int unsigned PULSE_CYC = vdc_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control from the unit
    input wire logic enable,
    input wire vdc_pkg::vdc_chan_in_t inp,
    // Channel result
    output vdc_pkg::vdc_chan_out_t outp
);

    vdc_pkg::vdc_chan_state_t st_reg;
    vdc_pkg::vdc_chan_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        // Tracked always, so a car already present at recovery is not a new entry
        st_next.veh_prev = inp.veh;
        if (!enable)
        begin
            st_next.pulse_cnt = vdc_pkg::CNT_W'(0);
            st_next.out = vdc_pkg::CHAN_RST.out;
        end
        else if (inp.fault)
        begin
            st_next.pulse_cnt = vdc_pkg::CNT_W'(0);
            st_next.out.drive_n = 1'b0;
            st_next.out.lamp = 1'b1;
        end
        else if (inp.presence_mode)
        begin
            st_next.pulse_cnt = vdc_pkg::CNT_W'(0);
            st_next.out.drive_n = !inp.veh;
            st_next.out.lamp = inp.veh;
        end
        else
        begin
            st_next.out.lamp = inp.veh;
            if (inp.veh && !st_reg.veh_prev && st_reg.pulse_cnt == vdc_pkg::CNT_W'(0))
            begin
                // One closure per entry; the output is low for exactly PULSE_CYC cycles
                st_next.pulse_cnt = vdc_pkg::CNT_W'(PULSE_CYC);
                st_next.out.drive_n = 1'b0;
            end
            else if (st_reg.pulse_cnt > vdc_pkg::CNT_W'(1))
            begin
                st_next.pulse_cnt = st_reg.pulse_cnt - vdc_pkg::CNT_W'(1);
                st_next.out.drive_n = 1'b0;
            end
            else
            begin
                st_next.pulse_cnt = vdc_pkg::CNT_W'(0);
                st_next.out.drive_n = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st_reg <= vdc_pkg::CHAN_RST;
        else
            st_reg <= st_next;
    end

    assign outp = st_reg.out;

endmodule

// [verification/vdc_ctl_model.sv]
// Controller detector-input model: pulled-up open-collector inputs and reset pin driver
`timescale 1ns/1ps
module vdc_ctl_model (
    // Clock
    input wire logic clk_sys,
    // Detector outputs as wired to the controller
    input wire logic [1:0] ctl_out_o,
    input wire logic [1:0] ctl_out_oe_n,
    // Controller side
    output logic det_reset_n,
    output logic [1:0] call
);
    // Pull-up keeps an input high unless the transistor conducts
    assign call = ~(ctl_out_o | ctl_out_oe_n);
    initial det_reset_n = 1'b1;
    // Ground-true reset pulse lasting n clocks
    task automatic send_reset(input int n);
        @(posedge clk_sys);
        det_reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        det_reset_n <= 1'b1;
    endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the two-channel detector output unit
`timescale 1ns/1ps
module tb_top;
    localparam int RCV = 50;
    localparam int PLS = 20;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] veh_detect = 2'h0;
    logic [1:0] winding_open = 2'h0;
    logic [1:0] winding_short = 2'h0;
    logic [1:0] mode_presence = 2'h3;
    logic [1:0] ctl_out_o;
    logic [1:0] ctl_out_oe_n;
    logic [1:0] ind_lamp;
    logic det_reset_n;
    logic [1:0] call;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] rnd = 32'h10ADA;
    logic [8:0] s1;
    logic [8:0] s2;
    logic mrec;
    logic [1:0] vp;
    logic [1:0] eoe;
    logic [1:0] elamp;
    int left;
    int rcnt;
    int hold = 5;
    int pcnt [2];

    always #25 clk_sys = ~clk_sys;

    vdc_top #(.RECOVER_CYC(RCV), .PULSE_CYC(PLS)) vdc_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .det_reset_n(det_reset_n), .veh_detect(veh_detect), .winding_open(winding_open),
        .winding_short(winding_short), .mode_presence(mode_presence), .ctl_out_o(ctl_out_o),
        .ctl_out_oe_n(ctl_out_oe_n), .ind_lamp(ind_lamp));
    vdc_ctl_model vdc_ctl_model_inst (.clk_sys(clk_sys), .ctl_out_o(ctl_out_o),
        .ctl_out_oe_n(ctl_out_oe_n), .det_reset_n(det_reset_n), .call(call));

    task automatic run(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic done(input string s);
        $display("Test %s finished, mismatches %0d", s, bad_count);
    endtask

    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Reference model; output at an edge follows the inputs sampled two edges earlier
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1 = 9'h100;
            s2 = 9'h100;
            mrec = 1'b1;
            left = RCV;
            rcnt = 0;
            hold = 5;
            vp = 2'h0;
            pcnt = '{0, 0};
            eoe = 2'h3;
            elamp = 2'h0;
        end
        else
        begin
            hold = (hold > 0) ? hold - 1 : 0;
            rcnt = s2[8] ? 0 : rcnt + 1;
            if (rcnt >= 300)
            begin
                hold = mrec ? hold : 5;
                mrec = 1'b1;
                left = RCV;
            end
            else if (mrec && left == 0)
            begin
                mrec = 1'b0;
                hold = 5;
            end
            else if (mrec)
                left--;
            for (int c = 0; c < 2; c++)
            begin
                elamp[c] = s2[c];
                if (mrec)
                begin
                    eoe[c] = 1'b1;
                    elamp[c] = 1'b0;
                    pcnt[c] = 0;
                end
                else if (s2[4+c] | s2[6+c])
                begin
                    eoe[c] = 1'b0;
                    elamp[c] = 1'b1;
                    pcnt[c] = 0;
                end
                else if (s2[2+c])
                begin
                    eoe[c] = !s2[c];
                    pcnt[c] = 0;
                end
                else if (pcnt[c] > 1)
                    pcnt[c]--;
                else if (pcnt[c] == 1)
                begin
                    // Closure ends; an entry in this same cycle is not taken
                    eoe[c] = 1'b1;
                    pcnt[c] = 0;
                end
                else
                begin
                    eoe[c] = !(s2[c] && !vp[c]);
                    pcnt[c] = eoe[c] ? 0 : PLS;
                end
                vp[c] = s2[c];
            end
            s2 = s1;
            s1 = {det_reset_n, winding_short, winding_open, mode_presence, veh_detect};
        end
    end

    // Recovery edges are left a few cycles of slack
    always @(negedge clk_sys)
        if (hold == 0)
            check({ctl_out_o, call, ind_lamp}, {2'h0, ~eoe, elamp});

    initial
    begin
        run(20);
        reset_n <= 1'b1;
        veh_detect <= 2'h1;
        run(30);
        veh_detect <= 2'h0;
        run(40);
        done("power-up recovery");
        mode_presence <= 2'h1;
        veh_detect <= 2'h1;
        run(5);
        veh_detect <= 2'h3;
        run(8);
        veh_detect <= 2'h1;
        run(2);
        veh_detect <= 2'h3;
        run(30);
        veh_detect <= 2'h1;
        run(1);
        veh_detect <= 2'h3;
        run(30);
        veh_detect <= 2'h0;
        run(10);
        done("pulse and held presence");
        for (int i = 0; i < 8; i++)
        begin
            mode_presence <= {2{i[2]}};
            winding_open <= i[1] ? 2'h0 : 2'h1 << i[0];
            winding_short <= i[1] ? 2'h1 << i[0] : 2'h0;
            run(10);
            winding_open <= 2'h0;
            winding_short <= 2'h0;
            run(10);
        end
        done("winding faults");
        mode_presence <= 2'h3;
        veh_detect <= 2'h1;
        run(5);
        vdc_ctl_model_inst.send_reset(299);
        run(10);
        vdc_ctl_model_inst.send_reset(300);
        run(RCV + 20);
        veh_detect <= 2'h0;
        run(10);
        done("controller reset");
        repeat (600)
        begin
            rnd = xs(rnd);
            veh_detect <= rnd[1:0];
            winding_open <= rnd[4:3] & rnd[6:5] & rnd[8:7];
            winding_short <= rnd[10:9] & rnd[12:11] & rnd[14:13];
            run(1 + rnd[17:15]);
        end
        veh_detect <= 2'h0;
        winding_open <= 2'h0;
        winding_short <= 2'h0;
        run(10);
        done("random presence and faults");
        print_verdict();
    end

    initial
    begin
        run(20000);
        bad_count++;
        $display("Watchdog expired at t=%0t", $time);
        print_verdict();
    end
endmodule
